// >>> include/rff_pkg.sv
// Package for the receive frame filter result and interrupt block.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz core clock.
package rff_pkg;
	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] RFF_OFS_CTRL = 8'h00;
	localparam logic [7:0] RFF_OFS_MASK = 8'h04;
	localparam logic [7:0] RFF_OFS_MATCH = 8'h08;
	localparam logic [7:0] RFF_OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] RFF_OFS_IRQ_MASK = 8'h10;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int RFF_CTRL_UNIT_EN_LSB = 0;
	localparam int RFF_CTRL_REMAP_LSB = 4;
	localparam int RFF_CTRL_PROMISC = 8;
	localparam int RFF_CTRL_CRC_FILT = 9;
	localparam int RFF_CTRL_AUTO_ACK = 10;
	localparam int RFF_MASK_TYPE_LSB = 0;
	localparam int RFF_MASK_VER_LSB = 8;
	localparam int RFF_MATCH_EXT = 4;
	localparam int RFF_IRQ_START = 0;
	localparam int RFF_IRQ_ADDR = 1;
	localparam int RFF_IRQ_EXT = 2;
	localparam int RFF_IRQ_END = 3;
	// ****************************************************************
	// Reset values and frame constants
	// ****************************************************************
	localparam logic [7:0] RFF_TYPE_MASK_RST = 8'h0B;
	localparam logic [3:0] RFF_VER_MASK_RST = 4'h3;
	localparam logic [2:0] RFF_TYPE_ACK = 3'h2;
	localparam logic [2:0] RFF_TYPE_DATA = 3'h1;
	localparam logic [2:0] RFF_TYPE_CMD = 3'h3;
	localparam logic [1:0] RFF_HTRANS_NONSEQ = 2'h2;
	// Frame progress of the receive path
	typedef enum logic [1:0] {
		RFF_IDLE = 2'b00,
		RFF_HDR = 2'b01,
		RFF_BODY = 2'b10
	} rff_state_t;
endpackage : rff_pkg

// >>> hdl/rff_top.sv
// Receive frame filter result logic: filter masks, per-unit match status,
// receive interrupts and the automatic acknowledgement trigger.
// Assumes the parser delivers per-unit third-level verdicts with the header
// done strobe, and the frame buffer signals completion with frame_done.
`timescale 1ns/1ns
module rff_top
	import rff_pkg::*;
#(
	parameter int NUM_UNITS = 4
) (
	input wire logic core_clk, // Baseband clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic clk_en, // Freezes all state while low
	input wire logic hsel, // AHB slave select
	input wire logic [7:0] haddr, // AHB address, low byte
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic hdr_valid, // Pulse: valid frame header detected
	input wire logic hdr_done, // Pulse: MAC header fully parsed
	input wire logic [2:0] frame_type, // Frame type, valid with hdr_done
	input wire logic [1:0] frame_version, // Frame version, valid with hdr_done
	input wire logic ack_request, // Ack request bit, valid with hdr_done
	input wire logic [NUM_UNITS-1:0] unit_rules_ok, // Third-level rules per unit
	input wire logic unit_rules_reserved, // Unit verdict computed as data type
	input wire logic ext_rule_hit, // At least one extended rule met
	input wire logic fcs_ok, // FCS valid, with frame_done
	input wire logic frame_done, // Pulse: frame stored in buffer
	output logic rx_start_irq, // Pulse: frame start
	output logic rx_addr_match_irq, // Pulse: address match
	output logic rx_ext_match_irq, // Pulse: extended match
	output logic rx_end_irq, // Pulse: frame end
	output logic auto_ack_trig, // Pulse: start automatic ack
	output logic irq // Level interrupt
);
	import rff_pkg::*;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [NUM_UNITS-1:0] filter_unit_enable_q;
	logic [NUM_UNITS-1:0] reserved_type_remap_q;
	logic promiscuous_rx_q;
	logic checksum_filter_enable_q;
	logic auto_ack_q;
	logic [7:0] frame_type_mask_q;
	logic [3:0] frame_version_mask_q;
	logic [NUM_UNITS-1:0] address_match_status_q;
	logic extended_match_flag_q;
	logic [3:0] irq_status_q;
	logic [3:0] irq_mask_q;
	logic ack_frame_q;
	logic ack_cand_q;
	rff_state_t state_q;

	// ****************************************************************
	// AHB-Lite slave, zero wait states
	// ****************************************************************
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rd_word;
	logic take;
	logic [3:0] w1c;

	assign take = hsel && hready && htrans[1];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata <= 32'h00000000;
		end else if (clk_en) begin
			if (hready) begin
				wr_pend_q <= take && hwrite;
			end
			if (take) begin
				wr_addr_q <= haddr;
			end
			hrdata <= (take && !hwrite) ? rd_word : 32'h00000000;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		case (haddr)
			RFF_OFS_CTRL: begin
				rd_word[RFF_CTRL_UNIT_EN_LSB +: NUM_UNITS] = filter_unit_enable_q;
				rd_word[RFF_CTRL_REMAP_LSB +: NUM_UNITS] = reserved_type_remap_q;
				rd_word[RFF_CTRL_PROMISC] = promiscuous_rx_q;
				rd_word[RFF_CTRL_CRC_FILT] = checksum_filter_enable_q;
				rd_word[RFF_CTRL_AUTO_ACK] = auto_ack_q;
			end
			RFF_OFS_MASK: begin
				rd_word[RFF_MASK_TYPE_LSB +: 8] = frame_type_mask_q;
				rd_word[RFF_MASK_VER_LSB +: 4] = frame_version_mask_q;
			end
			RFF_OFS_MATCH: begin
				rd_word[NUM_UNITS-1:0] = address_match_status_q;
				rd_word[RFF_MATCH_EXT] = extended_match_flag_q;
			end
			RFF_OFS_IRQ_STATUS: rd_word[3:0] = irq_status_q;
			RFF_OFS_IRQ_MASK: rd_word[3:0] = irq_mask_q;
			default: rd_word = 32'h00000000;
		endcase
	end

	// Configuration writes; unmapped addresses are ignored
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			filter_unit_enable_q <= '0;
			reserved_type_remap_q <= '0;
			promiscuous_rx_q <= 1'b0;
			checksum_filter_enable_q <= 1'b0;
			auto_ack_q <= 1'b0;
			frame_type_mask_q <= RFF_TYPE_MASK_RST;
			frame_version_mask_q <= RFF_VER_MASK_RST;
			irq_mask_q <= 4'h0;
		end else if (clk_en && wr_pend_q) begin
			case (wr_addr_q)
				RFF_OFS_CTRL: begin
					filter_unit_enable_q <= hwdata[RFF_CTRL_UNIT_EN_LSB +: NUM_UNITS];
					reserved_type_remap_q <= hwdata[RFF_CTRL_REMAP_LSB +: NUM_UNITS];
					promiscuous_rx_q <= hwdata[RFF_CTRL_PROMISC];
					checksum_filter_enable_q <= hwdata[RFF_CTRL_CRC_FILT];
					auto_ack_q <= hwdata[RFF_CTRL_AUTO_ACK];
				end
				RFF_OFS_MASK: begin
					frame_type_mask_q <= hwdata[RFF_MASK_TYPE_LSB +: 8];
					frame_version_mask_q <= hwdata[RFF_MASK_VER_LSB +: 4];
				end
				RFF_OFS_IRQ_MASK: irq_mask_q <= hwdata[3:0];
				default: ;
			endcase
		end
	end

	assign w1c = (wr_pend_q && wr_addr_q == RFF_OFS_IRQ_STATUS) ? hwdata[3:0] : 4'h0;

	// ****************************************************************
	// Filter decision at header completion
	// ****************************************************************
	logic filter_en;
	logic global_ok;
	logic reserved_t;
	logic is_ack;
	logic [NUM_UNITS-1:0] unit_hit;
	logic addr_hit;
	logic ext_hit;

	assign filter_en = |filter_unit_enable_q;
	assign global_ok = frame_type_mask_q[frame_type] &&
		frame_version_mask_q[frame_version];
	assign reserved_t = frame_type[2];
	assign is_ack = (frame_type == RFF_TYPE_ACK);

	// Reserved types only reach a unit whose remap bit is set, and then the
	// data-type verdict decides; the ordinary per-unit verdict does not apply
	assign unit_hit = filter_unit_enable_q &
		(reserved_t ? (reserved_type_remap_q & {NUM_UNITS{unit_rules_reserved}})
			: unit_rules_ok);
	assign addr_hit = global_ok && !is_ack && (|unit_hit);
	assign ext_hit = global_ok && !is_ack && ext_rule_hit;

	// Match status holds from one header completion to the next
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			address_match_status_q <= '0;
			extended_match_flag_q <= 1'b0;
			ack_frame_q <= 1'b0;
			ack_cand_q <= 1'b0;
		end else if (clk_en && hdr_done) begin
			address_match_status_q <= global_ok && !is_ack ? unit_hit : '0;
			extended_match_flag_q <= ext_hit;
			ack_frame_q <= is_ack;
			ack_cand_q <= auto_ack_q && filter_en && (|unit_hit) && ack_request &&
				(frame_type == RFF_TYPE_DATA || frame_type == RFF_TYPE_CMD);
		end
	end

	// ****************************************************************
	// Frame progress
	// ****************************************************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= RFF_IDLE;
		end else if (clk_en) begin
			case (state_q)
				RFF_IDLE: if (hdr_valid) state_q <= RFF_HDR;
				RFF_HDR: if (hdr_done) state_q <= RFF_BODY;
				RFF_BODY: if (frame_done) state_q <= RFF_IDLE;
				default: state_q <= RFF_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Interrupt pulses
	// ****************************************************************
	logic fcs_pass;
	logic end_ok;
	logic [3:0] ev;

	assign fcs_pass = fcs_ok || !checksum_filter_enable_q;
	assign end_ok = fcs_pass && (!filter_en || promiscuous_rx_q || ack_frame_q ||
		(|address_match_status_q) || extended_match_flag_q);

	assign ev[RFF_IRQ_START] = hdr_valid;
	assign ev[RFF_IRQ_ADDR] = hdr_done && state_q == RFF_HDR && filter_en && addr_hit;
	assign ev[RFF_IRQ_EXT] = hdr_done && state_q == RFF_HDR && filter_en && ext_hit;
	assign ev[RFF_IRQ_END] = frame_done && state_q == RFF_BODY && end_ok;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_start_irq <= 1'b0;
			rx_addr_match_irq <= 1'b0;
			rx_ext_match_irq <= 1'b0;
			rx_end_irq <= 1'b0;
			auto_ack_trig <= 1'b0;
		end else if (clk_en) begin
			rx_start_irq <= ev[RFF_IRQ_START];
			rx_addr_match_irq <= ev[RFF_IRQ_ADDR];
			rx_ext_match_irq <= ev[RFF_IRQ_EXT];
			rx_end_irq <= ev[RFF_IRQ_END];
			// Ack only follows a frame that also passed the end checks
			auto_ack_trig <= ev[RFF_IRQ_END] && ack_cand_q;
		end
	end

	// Sticky status: a new event wins over a same-cycle clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_q <= 4'h0;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_status_q <= (irq_status_q & ~w1c) | ev;
			irq <= |(((irq_status_q & ~w1c) | ev) & irq_mask_q);
		end
	end
endmodule : rff_top

// >>> sim/rff_checker.sv
// Port checks for the receive filter result and interrupt block.
// Assumes one clock domain and the constants of rff_pkg.
`timescale 1ns/1ns
module rff_checker
	import rff_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic arst_n, // Reset, low
	input wire logic clk_en, // Enable
	input wire logic hsel, // Select
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic hready, // Bus ready
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response
	input wire logic [31:0] hrdata, // Read data
	input wire logic hdr_valid, // Header seen
	input wire logic hdr_done, // Header parsed
	input wire logic [2:0] frame_type, // Type
	input wire logic ack_request, // Ack bit
	input wire logic frame_done, // Frame stored
	input wire logic rx_start_irq, // Start
	input wire logic rx_addr_match_irq, // Address
	input wire logic rx_ext_match_irq, // Extended
	input wire logic rx_end_irq, // End
	input wire logic auto_ack_trig // Ack start
);
	logic [2:0] type_q;
	logic areq_q;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	// Header fields are gone by frame end, so keep them for the ack check
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			type_q <= 3'h0;
			areq_q <= 1'b0;
		end else if (hdr_done) begin
			type_q <= frame_type;
			areq_q <= ack_request;
		end
	end
	// ********************************
	// Assertions
	// ********************************
	sequence s_hdr;
		hdr_valid && clk_en;
	endsequence
	sequence s_ackfrm;
		hdr_done && clk_en && frame_type == RFF_TYPE_ACK;
	endsequence
	a_start_follows: assert property (s_hdr |=> rx_start_irq)
		else $error("start pulse missing");
	a_start_cause: assert property (rx_start_irq |-> $past(hdr_valid))
		else $error("start pulse without header");
	a_addr_cause: assert property (rx_addr_match_irq |-> $past(hdr_done))
		else $error("address pulse without parsed header");
	a_ext_cause: assert property (rx_ext_match_irq |-> $past(hdr_done))
		else $error("extended pulse without parsed header");
	a_ackfrm_quiet: assert property (s_ackfrm |=> !rx_addr_match_irq && !rx_ext_match_irq)
		else $error("match pulse on ack frame");
	a_end_cause: assert property (rx_end_irq |-> $past(frame_done))
		else $error("end pulse before frame stored");
	a_end_single: assert property (rx_end_irq |=> !rx_end_irq)
		else $error("end pulse too long");
	a_ack_gate: assert property (auto_ack_trig |-> rx_end_irq && areq_q && type_q[0] && !type_q[2])
		else $error("ack start on wrong frame");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_idle: assert property (hrdata != 32'h0 |-> $past(hsel && hready && htrans[1] && !hwrite))
		else $error("read data outside read");
endmodule : rff_checker
bind rff_top rff_checker u_chk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .hdr_valid(hdr_valid), .hdr_done(hdr_done),
	.frame_type(frame_type), .ack_request(ack_request), .frame_done(frame_done),
	.rx_start_irq(rx_start_irq), .rx_addr_match_irq(rx_addr_match_irq),
	.rx_ext_match_irq(rx_ext_match_irq), .rx_end_irq(rx_end_irq), .auto_ack_trig(auto_ack_trig));

// >>> sim/rff_rx_src.sv
// Receive parser model: header, header parse and frame stored strobes.
// Assumes the caller paces frames; gap sets how slowly the frame ends.
`timescale 1ns/1ns
module rff_rx_src (
	input wire logic core_clk, // Clock
	output logic hdr_valid, // Header seen
	output logic hdr_done, // Header parsed
	output logic [2:0] frame_type, // Type
	output logic [1:0] frame_version, // Version
	output logic ack_request, // Ack bit
	output logic [3:0] unit_rules_ok, // Unit verdicts
	output logic unit_rules_reserved, // Remapped verdict
	output logic ext_rule_hit, // Extended hit
	output logic fcs_ok, // Checksum good
	output logic frame_done // Frame stored
);
	initial begin
		{hdr_valid, hdr_done, frame_type, frame_version, ack_request} = '0;
		{unit_rules_ok, unit_rules_reserved, ext_rule_hit, fcs_ok, frame_done} = '0;
	end
	task automatic send(input logic [2:0] ty, input logic [3:0] uo, input logic rs, ex, fc, ar,
		input int gap);
		@(posedge core_clk);
		hdr_valid <= 1'b1;
		@(posedge core_clk);
		hdr_valid <= 1'b0;
		@(posedge core_clk);
		{hdr_done, frame_type, frame_version, unit_rules_ok, unit_rules_reserved, ext_rule_hit,
			ack_request} <= {1'b1, ty, 2'h0, uo, rs, ex, ar};
		@(posedge core_clk);
		// Fields only hold with their strobe, so scramble them afterwards
		{hdr_done, frame_type, frame_version, unit_rules_ok, unit_rules_reserved, ext_rule_hit,
			ack_request} <= {1'b0, ~ty, 2'h3, ~uo, ~rs, ~ex, ~ar};
		repeat (gap) @(posedge core_clk);
		{frame_done, fcs_ok} <= {1'b1, fc};
		@(posedge core_clk);
		{frame_done, fcs_ok} <= {1'b0, ~fc};
	endtask : send
endmodule : rff_rx_src

// >>> sim/test_rff_top.sv
// Self-checking bench: AHB-Lite register tasks and frame scenarios.
// Assumes zero-wait bus answers and the parser model rff_rx_src.
`timescale 1ns/1ns
module test_rff_top;
	import rff_pkg::*;
	logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, clr;
	logic [7:0] haddr;
	logic [1:0] htrans, frame_version;
	logic [2:0] hsize, frame_type;
	logic [31:0] hwdata, hrdata, rd;
	logic [3:0] unit_rules_ok;
	logic hdr_valid, hdr_done, ack_request, unit_rules_reserved, ext_rule_hit, fcs_ok, frame_done;
	logic rx_start_irq, rx_addr_match_irq, rx_ext_match_irq, rx_end_irq, auto_ack_trig;
	logic [4:0] seen;
	int errors = 0;
	int total_checks = 0;
	rff_top DUT (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hdr_valid(hdr_valid),
		.hdr_done(hdr_done), .frame_type(frame_type), .frame_version(frame_version),
		.ack_request(ack_request), .unit_rules_ok(unit_rules_ok),
		.unit_rules_reserved(unit_rules_reserved), .ext_rule_hit(ext_rule_hit), .fcs_ok(fcs_ok),
		.frame_done(frame_done), .rx_start_irq(rx_start_irq), .rx_addr_match_irq(rx_addr_match_irq),
		.rx_ext_match_irq(rx_ext_match_irq), .rx_end_irq(rx_end_irq),
		.auto_ack_trig(auto_ack_trig), .irq(irq));
	rff_rx_src src (.core_clk(core_clk), .hdr_valid(hdr_valid), .hdr_done(hdr_done),
		.frame_type(frame_type), .frame_version(frame_version), .ack_request(ack_request),
		.unit_rules_ok(unit_rules_ok), .unit_rules_reserved(unit_rules_reserved),
		.ext_rule_hit(ext_rule_hit), .fcs_ok(fcs_ok), .frame_done(frame_done));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Pulses last one cycle, so collect them until the bench clears
	always @(posedge core_clk) begin
		seen <= clr ? 5'h0 : seen | {auto_ack_trig, rx_end_irq, rx_ext_match_irq,
			rx_addr_match_irq, rx_start_irq};
	end
	// ********************************
	// Tasks
	// ********************************
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task rdy_edge;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) begin
			errors++;
			give_verdict();
		end
	endtask : rdy_edge
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		{hsel, haddr, hwrite, htrans, hsize} <= {1'b1, a, wr, RFF_HTRANS_NONSEQ, 3'h2};
		rdy_edge();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		rdy_edge();
		rd = hrdata;
	endtask : ahb
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h0);
		chk(nm, ex, rd);
	endtask : rchk
	task frm(input logic [11:0] c, input logic [2:0] t, input logic [3:0] u, input logic [3:0] fl,
		input int g, input logic [3:0] x);
		ahb(1'b1, RFF_OFS_CTRL, {20'h0, c});
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		src.send(t, u, fl[3], fl[2], fl[1], fl[0], g);
		repeat (3) @(posedge core_clk);
		chk("pulses", {27'h0, x, 1'b1}, {27'h0, seen});
	endtask : frm
	// ********************************
	// Sequence
	// ********************************
	initial begin
		{hsel, hwrite, clr, haddr, htrans, hsize, hwdata, arst_n} = '0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rchk("mask", RFF_OFS_MASK, 32'h0000030B);
		rchk("match", RFF_OFS_MATCH, 32'h0);
		rchk("unmapped", 8'h14, 32'h0);
		frm(12'h000, 3'h1, 4'h0, 4'h2, 2, 4'h4);
		frm(12'h200, 3'h1, 4'h0, 4'h0, 2, 4'h0);
		frm(12'h000, 3'h1, 4'h0, 4'h0, 2, 4'h4);
		frm(12'h201, 3'h1, 4'h1, 4'h2, 20, 4'h5);
		frm(12'h201, 3'h1, 4'h0, 4'h2, 2, 4'h0);
		frm(12'h301, 3'h1, 4'h0, 4'h2, 2, 4'h4);
		frm(12'h201, 3'h1, 4'h0, 4'h6, 2, 4'h6);
		rchk("match", RFF_OFS_MATCH, 32'h10);
		frm(12'h201, 3'h2, 4'hF, 4'h6, 2, 4'h4);
		frm(12'h601, 3'h1, 4'h1, 4'h3, 2, 4'hD);
		frm(12'h601, 3'h3, 4'h1, 4'h3, 2, 4'hD);
		frm(12'h601, 3'h1, 4'h1, 4'h2, 2, 4'h5);
		frm(12'h604, 3'h0, 4'h4, 4'h3, 2, 4'h5);
		ahb(1'b1, RFF_OFS_MATCH, 32'h1F);
		rchk("match", RFF_OFS_MATCH, 32'h04);
		ahb(1'b1, RFF_OFS_MASK, 32'hFFF);
		rchk("mask", RFF_OFS_MASK, 32'hFFF);
		frm(12'h211, 3'h5, 4'h0, 4'hE, 2, 4'h7);
		ahb(1'b1, RFF_OFS_MASK, 32'h309);
		frm(12'h201, 3'h1, 4'h1, 4'h2, 2, 4'h0);
		ahb(1'b1, RFF_OFS_MASK, 32'h20B);
		frm(12'h201, 3'h1, 4'h1, 4'h6, 2, 4'h0);
		rchk("status", RFF_OFS_IRQ_STATUS, 32'hF);
		chk("irq", 32'h0, {31'h0, irq});
		ahb(1'b1, RFF_OFS_IRQ_MASK, 32'h8);
		repeat (2) @(posedge core_clk);
		chk("irq", 32'h1, {31'h0, irq});
		ahb(1'b1, RFF_OFS_IRQ_STATUS, 32'h8);
		repeat (2) @(posedge core_clk);
		chk("irq", 32'h0, {31'h0, irq});
		rchk("status", RFF_OFS_IRQ_STATUS, 32'h7);
		give_verdict();
	end
endmodule : test_rff_top
